// File: pic_defines.svh
// register offsets, field positions, reset values and widths of the interrupt controller
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH
`define PIC_NLINE 8
`define PIC_NSRC 16
`define PIC_OFF_ENABLE 8'h00
`define PIC_OFF_PEND 8'h04
`define PIC_OFF_SENSE 8'h08
`define PIC_OFF_PRIO_A 8'h0C
`define PIC_OFF_PRIO_B 8'h10
`define PIC_OFF_SYSCTL 8'h14
`define PIC_OFF_CCR 8'h18
`define PIC_OFF_STATUS 8'h1C
`define PIC_OFF_MASK 8'h20
`define PIC_OFF_CURRENT 8'h24
`define PIC_CCR_I_BIT 7
`define PIC_CCR_UI_BIT 6
`define PIC_SYS_UE_BIT 0
`define PIC_CUR_VALID_BIT 8
`define PIC_RST_ENABLE 8'h00
`define PIC_RST_SENSE 8'h00
`define PIC_RST_PRIO 8'h00
`define PIC_RST_CCR 8'h80
`define PIC_RST_SYSCTL 8'h01
`define PIC_ST_EDGE 0
`define PIC_ST_PRESENT 1
`define PIC_RESP_OKAY 2'h0
`define PIC_RESP_SLVERR 2'h2
`endif

// File: pic_pkg.sv
// types shared by the interrupt controller modules
package pic_pkg;
   typedef logic [7:0] pic_byte_t;
   typedef logic [3:0] pic_src_t;
   typedef logic [15:0] pic_vec_t;
endpackage

// File: pic_sense_if.sv
// carrier between the register side and the external line sense logic
`timescale 1ns/100ps
interface pic_sense_if;
   logic [7:0] sense_edge;
   logic [7:0] pend;
   logic [7:0] clr_mask;
   logic clr_we;
   logic [7:0] accept_clr;
   logic standby_clr;
   logic [7:0] line_low;
   modport ctl (output sense_edge, output clr_mask, output clr_we, output accept_clr,
                output standby_clr, input pend, input line_low);
   modport sen (input sense_edge, input clr_mask, input clr_we, input accept_clr,
                input standby_clr, output pend, output line_low);
endinterface

// File: pic_line_sense.sv
// synchronisers, sense detection and pending flags of the external request lines
`timescale 1ns/100ps
`include "pic_defines.svh"
module pic_line_sense (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // pins
   input wire logic [7:0] external_request_line_n,
   // register side
   pic_sense_if.sen sif
);
   import pic_pkg::*;

   logic [7:0] sync1_r;
   logic [7:0] sync2_r;
   logic [7:0] prev_r;
   logic [7:0] pend_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= 8'hFF;
         sync2_r <= 8'hFF;
         prev_r <= 8'hFF;
      end else begin
         sync1_r <= external_request_line_n;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // ==========================================================
   // pending flags
   genvar k;
   generate
      for (k = 0; k < `PIC_NLINE; k = k + 1) begin : g_line
         logic hit;
         // R1: no glitch filter
         // a slow edge may bounce through the synchroniser and set the flag repeatedly
         assign hit = sif.sense_edge[k] ? (prev_r[k] & ~sync2_r[k]) : ~sync2_r[k];
         // R10: flag ignores enable
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               pend_r[k] <= 1'b0;
            end else if (hit) begin
               pend_r[k] <= 1'b1;
            end else if (sif.standby_clr || sif.accept_clr[k]
                         || (sif.clr_we && !sif.clr_mask[k])) begin
               pend_r[k] <= 1'b0;
            end
         end
         // R10: level sense sets flag
         a_level_sets: assert property (@(posedge aclk) disable iff (!aresetn) // R10
            (!sif.sense_edge[k] && !sync2_r[k]) |=> pend_r[k])
            else $error("level request did not set its pending flag");
      end
   endgenerate

   assign sif.pend = pend_r;
   assign sif.line_low = ~sync2_r;
endmodule

// File: pic_ctrl.sv
// priority interrupt controller with an AXI4-Lite register slave
`timescale 1ns/100ps
`include "pic_defines.svh"
// Notes on behaviour
// R1: slow edges may raise several requests
// R2: enable clear acts at instruction end
// R3: requests during clearing instruction are dropped
// R4: held flag accepted once enable set
// R5: masking state admits priority-one sources only
// R6: zero priority bit masks that source
// R7: standby exit clears all enable bits
// R8: held level accepted after enable set
// R9: user mask is condition code bit 6
// R10: flag set by sense, independent of enable
// R11: highest pending request sampled at boundaries
module pic_ctrl (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // request sources
   input wire logic [7:0] external_request_line_n,
   input wire logic [7:0] periph_req,
   input wire logic hw_standby,
   // cpu core
   input wire logic cpu_insn_end,
   input wire logic cpu_accept,
   output logic cpu_req_valid,
   output pic_pkg::pic_src_t cpu_req_id,
   // interrupt
   output logic irq
);
   import pic_pkg::*;

   pic_sense_if sif ();

   pic_line_sense u_sense (
      .aclk(aclk),
      .aresetn(aresetn),
      .external_request_line_n(external_request_line_n),
      .sif(sif)
   );

   pic_byte_t request_enable_register_r;
   pic_byte_t sense_control_register_r;
   pic_byte_t priority_register_a_r;
   pic_byte_t priority_register_b_r;
   pic_byte_t system_control_register_r;
   pic_byte_t condition_code_register_r;
   logic [1:0] status_r;
   logic [1:0] mask_r;
   logic req_valid_r;
   pic_src_t req_id_r;
   logic irq_r;
   logic stb_s1_r;
   logic stb_s2_r;
   logic stb_prev_r;
   logic awready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   // ==========================================================
   // helpers
   function automatic logic reg_known(input logic [7:0] a);
      reg_known = (a <= `PIC_OFF_CURRENT) && (a[1:0] == 2'h0);
   endfunction

   // R5: mask decode
   function automatic logic mask_open(input logic prio, input pic_byte_t condition_code_register,
                                      input logic ue);
      logic i_bit;
      logic ui_bit;
      i_bit = condition_code_register[`PIC_CCR_I_BIT];
      ui_bit = condition_code_register[`PIC_CCR_UI_BIT];
      if (!i_bit) begin
         mask_open = 1'b1;
      end else if (!ue && !ui_bit) begin
         mask_open = prio;
      end else begin
         mask_open = 1'b0;
      end
   endfunction

   // ==========================================================
   // bus handshake
   logic wr_go;
   logic rd_go;
   logic standby_exit;
   logic [7:0] wd;
   assign wr_go = awready_r && s_axi_awvalid && s_axi_wvalid;
   assign rd_go = arready_r && s_axi_arvalid;
   assign wd = s_axi_wdata[7:0];
   // R7: standby release edge
   assign standby_exit = stb_prev_r && !stb_s2_r;

   // address and data are taken together; one outstanding transfer per direction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `PIC_RESP_OKAY;
      end else begin
         awready_r <= s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= reg_known(s_axi_awaddr) ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stb_s1_r <= 1'b0;
         stb_s2_r <= 1'b0;
         stb_prev_r <= 1'b0;
      end else begin
         stb_s1_r <= hw_standby;
         stb_s2_r <= stb_s1_r;
         stb_prev_r <= stb_s2_r;
      end
   end

   // ==========================================================
   // control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         request_enable_register_r <= `PIC_RST_ENABLE;
         sense_control_register_r <= `PIC_RST_SENSE;
         priority_register_a_r <= `PIC_RST_PRIO;
         priority_register_b_r <= `PIC_RST_PRIO;
         system_control_register_r <= `PIC_RST_SYSCTL;
         condition_code_register_r <= `PIC_RST_CCR;
         mask_r <= 2'h0;
      end else if (standby_exit) begin
         // R7: enables reinitialised
         request_enable_register_r <= `PIC_RST_ENABLE;
      end else if (wr_go && s_axi_wstrb[0]) begin
         case (s_axi_awaddr)
            `PIC_OFF_ENABLE: request_enable_register_r <= wd;
            `PIC_OFF_SENSE: sense_control_register_r <= wd;
            // R6: zero bit masks
            `PIC_OFF_PRIO_A: priority_register_a_r <= wd;
            `PIC_OFF_PRIO_B: priority_register_b_r <= wd;
            `PIC_OFF_SYSCTL: system_control_register_r <= wd;
            // R9: user mask at bit 6
            `PIC_OFF_CCR: condition_code_register_r <= wd;
            `PIC_OFF_MASK: mask_r <= wd[1:0];
            default: mask_r <= mask_r;
         endcase
      end
   end

   assign sif.sense_edge = sense_control_register_r;
   assign sif.clr_mask = wd;
   assign sif.clr_we = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == `PIC_OFF_PEND);
   assign sif.standby_clr = standby_exit;
   assign sif.accept_clr = (cpu_accept && req_valid_r && !req_id_r[3])
                           ? (sense_control_register_r & (8'h01 << req_id_r[2:0])) : 8'h00;

   // ==========================================================
   // request selection
   pic_vec_t cand;
   pic_vec_t prio;
   pic_src_t pick_id;
   logic pick_any;
   always_comb begin
      // R2: gated by the enable only when sampled at the boundary
      cand = {periph_req, sif.pend & request_enable_register_r};
      prio = {priority_register_b_r, priority_register_a_r};
      pick_any = 1'b0;
      pick_id = 4'h0;
      // R11: priority-one group first, lowest index wins
      for (int g = 1; g >= 0; g--) begin
         for (int k = `PIC_NSRC - 1; k >= 0; k--) begin
            if (cand[k] && prio[k] == g[0] && !pick_any
                && mask_open(prio[k], condition_code_register_r,
                             system_control_register_r[`PIC_SYS_UE_BIT])) begin
               pick_id = 4'(k);
            end
         end
         for (int k = 0; k < `PIC_NSRC; k++) begin
            if (cand[k] && prio[k] == g[0]
                && mask_open(prio[k], condition_code_register_r,
                             system_control_register_r[`PIC_SYS_UE_BIT])) begin
               pick_any = 1'b1;
            end
         end
      end
   end

   // R3: sampling only at instruction end drops requests of a disabled source
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_valid_r <= 1'b0;
         req_id_r <= 4'h0;
      end else if (standby_exit) begin
         req_valid_r <= 1'b0;
      end else if (cpu_insn_end) begin
         // R4: held flag taken here
         // R8: held level taken here
         req_valid_r <= pick_any;
         req_id_r <= pick_id;
      end else if (cpu_accept) begin
         req_valid_r <= 1'b0;
      end
   end

   // ==========================================================
   // read path and event status
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0;
      case (s_axi_araddr)
         `PIC_OFF_ENABLE: rd_val[7:0] = request_enable_register_r;
         `PIC_OFF_PEND: rd_val[7:0] = sif.pend;
         `PIC_OFF_SENSE: rd_val[7:0] = sense_control_register_r;
         `PIC_OFF_PRIO_A: rd_val[7:0] = priority_register_a_r;
         `PIC_OFF_PRIO_B: rd_val[7:0] = priority_register_b_r;
         `PIC_OFF_SYSCTL: rd_val[7:0] = system_control_register_r;
         `PIC_OFF_CCR: rd_val[7:0] = condition_code_register_r;
         `PIC_OFF_STATUS: rd_val[1:0] = status_r;
         `PIC_OFF_MASK: rd_val[1:0] = mask_r;
         `PIC_OFF_CURRENT: rd_val[8:0] = {req_valid_r, 4'h0, req_id_r};
         default: rd_val = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= `PIC_RESP_OKAY;
      end else begin
         arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
         if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= reg_known(s_axi_araddr) ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // a new event in the clearing read cycle survives the clear
   logic [1:0] ev;
   logic [7:0] low_prev_r;
   assign ev = {cpu_insn_end && pick_any, |(sif.line_low & ~low_prev_r)};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= 2'h0;
         irq_r <= 1'b0;
         low_prev_r <= 8'h00;
      end else begin
         low_prev_r <= sif.line_low;
         status_r <= ((rd_go && s_axi_araddr == `PIC_OFF_STATUS) ? 2'h0 : status_r) | ev;
         irq_r <= |(status_r & mask_r);
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = awready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign cpu_req_valid = req_valid_r;
   assign cpu_req_id = req_id_r;
   assign irq = irq_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_quiet;
      !cpu_insn_end && !cpu_accept && !standby_exit;
   endsequence

   logic open_all;
   assign open_all = !condition_code_register_r[`PIC_CCR_I_BIT];

   a_standby_clear: assert property (standby_exit |=> request_enable_register_r == 8'h00) // R7
      else $error("enables survived standby exit");
   a_req_stable: assert property (s_quiet |=> $stable(req_id_r) && $stable(req_valid_r)) // R2
      else $error("presented request changed between boundaries");
   a_no_stale: assert property (cpu_insn_end && !standby_exit ##1 req_valid_r && !req_id_r[3]
      |-> |(($past(request_enable_register_r) >> req_id_r[2:0]) & 8'h01)) // R3
      else $error("disabled source was presented");
   a_held_taken: assert property (cpu_insn_end && open_all && !standby_exit
      && |(sif.pend & request_enable_register_r) |=> req_valid_r) // R4
      else $error("held enabled request not presented");
   a_prio_only: assert property (req_valid_r && !system_control_register_r[`PIC_SYS_UE_BIT]
      && $past(cpu_insn_end) && $past(condition_code_register_r) == 8'h80
      |-> |(($past(prio) >> req_id_r) & 16'h0001)) // R5
      else $error("low priority source passed the mask");
   a_zero_masks: assert property (cpu_insn_end && !standby_exit
      && condition_code_register_r[7:6] == 2'b10 && !system_control_register_r[0]
      && prio == 16'h0000 |=> !req_valid_r) // R6
      else $error("source with zero priority bit accepted");
   a_level_taken: assert property (cpu_insn_end && open_all && !standby_exit
      && |(sif.line_low & $past(sif.line_low)
           & ~sense_control_register_r & request_enable_register_r)
      |=> req_valid_r) // R8
      else $error("asserted level request not accepted");
   a_ui_masks: assert property (cpu_insn_end && condition_code_register_r[7:6] == 2'b11
      && !system_control_register_r[0] |=> !req_valid_r) // R9
      else $error("user mask bit did not mask");
   a_irq_follows: assert property (|(status_r & mask_r) |=> irq) // R11
      else $error("interrupt output missed a masked-in event");
endmodule

// File: pic_cpu_model.sv
// cpu core model: instruction boundaries and acceptance of presented requests
`timescale 1ns/100ps
module pic_cpu_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // controls from the bench
   input wire logic run,
   input wire logic accept_en,
   // controller side
   input wire logic cpu_req_valid,
   input wire pic_pkg::pic_src_t cpu_req_id,
   output logic cpu_insn_end,
   output logic cpu_accept,
   // record of acceptances
   output pic_pkg::pic_src_t taken_id,
   output int taken_cnt
);
   import pic_pkg::*;
   logic [1:0] phase_r;
   // ==========================================
   // instruction cadence
   // ==========================================
   // accept lands between boundaries, so it never meets an insn_end in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_r <= 2'h0;
         cpu_insn_end <= 1'b0;
         cpu_accept <= 1'b0;
      end else begin
         phase_r <= phase_r + 2'h1;
         cpu_insn_end <= run && (phase_r == 2'h0);
         cpu_accept <= accept_en && cpu_req_valid && (phase_r == 2'h2);
      end
   end
   // ==========================================
   // acceptance record
   // ==========================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         taken_id <= 4'h0;
         taken_cnt <= 0;
      end else if (cpu_accept && cpu_req_valid) begin
         taken_id <= cpu_req_id;
         taken_cnt <= taken_cnt + 1;
      end
   end
endmodule

// File: tb_top.sv
// self-checking bench of the priority interrupt controller
`timescale 1ns/100ps
`include "pic_defines.svh"
module tb_top;
   import pic_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] pins = 8'hFF;
   logic [7:0] periph = 8'h00;
   logic standby = 1'b0, run = 1'b0, acc_en = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, req_valid, irq, insn_end, accept;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   pic_src_t req_id, taken_id;
   int taken_cnt;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #12.5 aclk = ~aclk;
   pic_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .external_request_line_n(pins), .periph_req(periph),
      .hw_standby(standby), .cpu_insn_end(insn_end), .cpu_accept(accept),
      .cpu_req_valid(req_valid), .cpu_req_id(req_id), .irq(irq));
   pic_cpu_model u_cpu (.aclk(aclk), .aresetn(aresetn), .run(run), .accept_en(acc_en),
      .cpu_req_valid(req_valid), .cpu_req_id(req_id), .cpu_insn_end(insn_end),
      .cpu_accept(accept), .taken_id(taken_id), .taken_cnt(taken_cnt));
   // ==========================================
   // common tasks
   // ==========================================
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // write address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 64);
      chk("write answered", {31'h0, bvalid}, 32'h1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 64);
      chk("read answered", {31'h0, rvalid}, 32'h1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk("bresp", {30'h0, r}, {30'h0, `PIC_RESP_OKAY});
   endtask
   task automatic settle;
      repeat (16) @(posedge aclk);
   endtask
   task automatic wait_take(input pic_src_t id);
      int c, n;
      c = taken_cnt;
      n = 0;
      while (taken_cnt == c && n < 40) begin
         @(posedge aclk);
         n++;
      end
      chk("request taken", 32'(taken_cnt != c), 32'h1);
      chk("taken id", {28'h0, taken_id}, {28'h0, id});
   endtask
   // stale presentations are flushed first, then nothing may be taken
   task automatic no_take;
      int c;
      settle;
      c = taken_cnt;
      settle;
      chk("nothing taken", 32'(taken_cnt), 32'(c));
   endtask
   // ==========================================
   // scenarios
   // ==========================================
   task automatic t_reset_map;
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] offs [6] = '{`PIC_OFF_ENABLE, `PIC_OFF_SENSE, `PIC_OFF_PRIO_A,
                               `PIC_OFF_PRIO_B, `PIC_OFF_SYSCTL, `PIC_OFF_CCR};
      logic [7:0] vals [6] = '{`PIC_RST_ENABLE, `PIC_RST_SENSE, `PIC_RST_PRIO,
                               `PIC_RST_PRIO, `PIC_RST_SYSCTL, `PIC_RST_CCR};
      for (int i = 0; i < 6; i++) begin
         rd(offs[i], d, r);
         chk("reset value", d, {24'h0, vals[i]});
         chk("read resp", {30'h0, r}, {30'h0, `PIC_RESP_OKAY});
      end
      rd(8'h28, d, r);
      chk("unmapped read resp", {30'h0, r}, {30'h0, `PIC_RESP_SLVERR});
      chk("unmapped read data", d, 32'h0);
      wr(8'h40, 32'hFF, r);
      chk("unmapped write resp", {30'h0, r}, {30'h0, `PIC_RESP_SLVERR});
   endtask
   task automatic t_pending_held;
      logic [31:0] d;
      logic [1:0] r;
      w(`PIC_OFF_SENSE, 32'h01);
      w(`PIC_OFF_CCR, 32'h00);
      @(posedge aclk);
      pins <= 8'hFE;
      no_take;
      rd(`PIC_OFF_PEND, d, r);
      chk("flag without enable", d & 32'h1, 32'h1);
      w(`PIC_OFF_ENABLE, 32'h01);
      wait_take(4'h0);
      @(posedge aclk);
      pins <= 8'hFF;
      w(`PIC_OFF_ENABLE, 32'h00);
   endtask
   task automatic t_priority_mask;
      w(`PIC_OFF_SYSCTL, 32'h00);
      w(`PIC_OFF_CCR, 32'h80);
      w(`PIC_OFF_PRIO_B, 32'h02);
      @(posedge aclk);
      periph <= 8'h01;
      no_take;
      periph <= 8'h03;
      wait_take(4'h9);
      w(`PIC_OFF_PRIO_B, 32'h00);
      no_take;
      w(`PIC_OFF_PRIO_B, 32'h02);
      w(`PIC_OFF_CCR, 32'hC0);
      no_take;
      w(`PIC_OFF_CCR, 32'hC0 & 32'hBF);
      wait_take(4'h9);
      @(posedge aclk);
      periph <= 8'h00;
   endtask
   task automatic t_standby;
      logic [31:0] d;
      logic [1:0] r;
      w(`PIC_OFF_CCR, 32'h00);
      w(`PIC_OFF_SENSE, 32'h00);
      w(`PIC_OFF_ENABLE, 32'h02);
      @(posedge aclk);
      pins <= 8'hFD;
      wait_take(4'h1);
      standby <= 1'b1;
      repeat (8) @(posedge aclk);
      standby <= 1'b0;
      // the standby pin passes a synchroniser before the release acts
      repeat (4) @(posedge aclk);
      rd(`PIC_OFF_ENABLE, d, r);
      chk("enables after standby", d, 32'h0);
      no_take;
      w(`PIC_OFF_ENABLE, 32'h02);
      wait_take(4'h1);
      @(posedge aclk);
      pins <= 8'hFF;
      w(`PIC_OFF_ENABLE, 32'h00);
   endtask
   task automatic t_irq;
      logic [31:0] d;
      logic [1:0] r;
      settle;
      rd(`PIC_OFF_STATUS, d, r);
      w(`PIC_OFF_MASK, 32'h01);
      w(`PIC_OFF_SENSE, 32'h04);
      @(posedge aclk);
      pins <= 8'hFB;
      repeat (8) @(posedge aclk);
      chk("irq raised", {31'h0, irq}, 32'h1);
      rd(`PIC_OFF_STATUS, d, r);
      chk("status event", d & 32'h1, 32'h1);
      repeat (4) @(posedge aclk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      pins <= 8'hFF;
      w(`PIC_OFF_MASK, 32'h00);
      @(posedge aclk);
      pins <= 8'hFB;
      repeat (8) @(posedge aclk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      rd(`PIC_OFF_STATUS, d, r);
      chk("masked event kept", d & 32'h1, 32'h1);
      w(`PIC_OFF_PEND, 32'h00);
      rd(`PIC_OFF_PEND, d, r);
      chk("pending cleared by write", d, 32'h0);
      pins <= 8'hFF;
   endtask
   // ==========================================
   // main sequence and hang guard
   // ==========================================
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         end_sim;
      end
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      run <= 1'b1;
      acc_en <= 1'b1;
      @(posedge aclk);
      t_reset_map;
      t_pending_held;
      t_priority_mask;
      t_standby;
      t_irq;
      end_sim;
   end
endmodule
